// ### rtl/lpi_map.svh
// Purpose: named constants for the power-up sequencer of a low-power DDR memory
// Assumes: 20 MHz controller clock (50 ns period)
// Notes: all times in their printed units, cycle counts derived from them
`ifndef LPI_MAP_SVH
`define LPI_MAP_SVH
`define LPI_CLK_PERIOD_PS 50000
`define LPI_GATE_LOW_NS 100
`define LPI_CLOCK_LEAD_CYCLES 5
`define LPI_IDLE_US 200
`define LPI_RESET_IDLE_US 1
`define LPI_AUTO_INIT_MAX_US 10
`define LPI_CAL_US 1
`define LPI_BOOT_PERIOD_MIN_NS 18
`define LPI_BOOT_PERIOD_MAX_NS 100
// mode register addresses, operands and the auto-init status bit
`define LPI_MA_INFO 8'h00
`define LPI_MA_RESET 8'h3F
`define LPI_MA_CAL 8'h0A
`define LPI_OP_RESET 8'h00
`define LPI_OP_CAL_INIT 8'hFF
`define LPI_AUTO_INIT_BIT 0
// command codes on the command/address bus (rising half, bits 3:0)
`define LPI_CA_NOP 10'h007
`define LPI_CA_MRW 4'h0
`define LPI_CA_MRR 4'h8
`endif

// ### rtl/lpi_pkg.sv
// Purpose: types for the power-up sequencer
// Assumes: nothing
// Notes: constants live in lpi_map.svh
package lpi_pkg;
  typedef enum logic [3:0] {
    LPI_GATE_LOW, LPI_CLK_LEAD, LPI_IDLE, LPI_RESET_CMD, LPI_RESET_IDLE,
    LPI_POLL_CMD, LPI_POLL_WAIT, LPI_CAL_GRANT, LPI_CAL_CMD, LPI_CAL_WAIT, LPI_READY
  } lpi_state_e;
  typedef logic [19:0] lpi_count_t;
endpackage

// ### rtl/lpi_seq.sv
// Purpose: controller-side power-up and initialisation sequencer for a DDR memory
// Assumes: supplies_ok pin rises when all rails are in range; clk is the memory clock
// Notes: commands are driven one per clock, both halves of the 10-bit bus presented
// Notes on behaviour
// - keep clock enable low at least 100 ns after supplies are good.
// - run the clock at least five periods before clock enable first rises.
// - mode register reads only with clock period between 18 and 100 ns; the code issues them at any CLK_PS.
// - mode register writes allowed at normal clock if timing is met.
// - after enable rises, issue only no-ops for at least 200 us.
// - then issue the reset mode register write; precharge-all optional.
// - after reset, keep enable high and issue only no-ops.
// - the post-reset no-op interval lasts at least 1 us.
// - then only mode register reads or power-down until auto-init ends.
// - clock enable may drop then only per power-down rules.
// - proceed only after the maximum time or a completion read-back.
// - use relaxed boot timing until output buffers are configured.
// - after auto-init, calibration may be issued as write to calibration register.
// - calibration commands of memories sharing a bus never overlap.
// - each command takes one clock, both clock edges carry bits.
// - activate selects row and bank, read/write selects bank and column.
`timescale 1ns/1ps
`include "lpi_map.svh"
module lpi_seq import lpi_pkg::*; #(
  parameter int CLK_PS = `LPI_CLK_PERIOD_PS,
  parameter int IDLE_CYCLES = (`LPI_IDLE_US * 1000000 + CLK_PS - 1) / CLK_PS,
  parameter int POLL_GAP = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic supplies_ok,
  input wire logic start,
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire logic cal_grant,
  output logic clk_run,
  output logic clk_enable,
  output logic [9:0] ca_rise,
  output logic [9:0] ca_fall,
  output logic ca_drive_n,
  output logic cal_request,
  output logic boot_timing,
  output logic ready,
  output logic auto_init_timeout
);
  // rounding up of every minimum wait
  localparam int GATE_LOW_CYC = (`LPI_GATE_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RST_IDLE_CYC = (`LPI_RESET_IDLE_US * 1000000 + CLK_PS - 1) / CLK_PS;
  localparam int AUTO_MAX_CYC = (`LPI_AUTO_INIT_MAX_US * 1000000 + CLK_PS - 1) / CLK_PS;
  localparam int CAL_CYC = (`LPI_CAL_US * 1000000 + CLK_PS - 1) / CLK_PS;
  // the boot clock range only matters for reads; a compile-time check of range
  localparam bit BOOT_CLK_OK = (CLK_PS >= `LPI_BOOT_PERIOD_MIN_NS * 1000) &&
                               (CLK_PS <= `LPI_BOOT_PERIOD_MAX_NS * 1000);
  // the enable register adds the last lead cycle, so the timer counts one fewer
  localparam int LEAD_CYC = `LPI_CLOCK_LEAD_CYCLES - 1;
  // named copies so the address can be split across the two bus halves
  localparam logic [7:0] MA_RESET = `LPI_MA_RESET;
  localparam logic [7:0] MA_INFO = `LPI_MA_INFO;
  localparam logic [7:0] MA_CAL = `LPI_MA_CAL;

  lpi_state_e state_r;
  logic sup_s1_r, sup_s2_r, sup_s3_r, sup_r;
  logic tmr_load;
  lpi_count_t tmr_val;
  logic tmr_done;
  logic [19:0] auto_cnt_r;
  logic [3:0] gap_r;

  // ----------------------------------------------------------------
  // supply-good synchroniser: change taken once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sup_s1_r <= 1'b0;
      sup_s2_r <= 1'b0;
      sup_s3_r <= 1'b0;
      sup_r <= 1'b0;
    end else begin
      sup_s1_r <= supplies_ok;
      sup_s2_r <= sup_s1_r;
      sup_s3_r <= sup_s2_r;
      if (sup_s2_r == sup_s3_r) begin
        sup_r <= sup_s3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // interval timer
  // ----------------------------------------------------------------
  lpi_timer #(.WIDTH(20)) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // timer loads on each state entry that starts a wait
  always_comb begin
    tmr_load = 1'b0;
    tmr_val = '0;
    unique case (state_r)
      LPI_GATE_LOW: begin
        if (!(sup_r && start)) begin
          tmr_load = 1'b1;
          tmr_val = lpi_count_t'(GATE_LOW_CYC);
        end else if (tmr_done) begin
          // clock starts now; count the lead before enable may rise
          tmr_load = 1'b1;
          tmr_val = lpi_count_t'(LEAD_CYC);
        end
      end
      LPI_CLK_LEAD: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val = lpi_count_t'(IDLE_CYCLES);
        end
      end
      LPI_RESET_CMD: begin
        tmr_load = 1'b1;
        tmr_val = lpi_count_t'(RST_IDLE_CYC);
      end
      LPI_CAL_CMD: begin
        tmr_load = 1'b1;
        tmr_val = lpi_count_t'(CAL_CYC);
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // auto-init watchdog, counts from the reset command
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      auto_cnt_r <= '0;
    end else if (state_r == LPI_RESET_CMD) begin
      auto_cnt_r <= 20'(AUTO_MAX_CYC);
    end else if (auto_cnt_r != '0) begin
      auto_cnt_r <= auto_cnt_r - 1'b1;
    end
  end

  // spacing between polling reads so replies can come back
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_r <= '0;
    end else if (state_r == LPI_POLL_CMD) begin
      gap_r <= 4'(POLL_GAP);
    end else if (gap_r != '0) begin
      gap_r <= gap_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequence state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= LPI_GATE_LOW;
    end else begin
      unique case (state_r)
        // gate low timer keeps reloading until supplies are good and start is high
        LPI_GATE_LOW: if (sup_r && start && tmr_done) state_r <= LPI_CLK_LEAD;
        // clock runs here while enable is still low; timer counted the lead
        LPI_CLK_LEAD: if (tmr_done) state_r <= LPI_IDLE;
        LPI_IDLE: if (tmr_done) state_r <= LPI_RESET_CMD;
        LPI_RESET_CMD: state_r <= LPI_RESET_IDLE;
        LPI_RESET_IDLE: if (tmr_done) state_r <= LPI_POLL_CMD;
        LPI_POLL_CMD: state_r <= LPI_POLL_WAIT;
        LPI_POLL_WAIT: begin
          // completion read-back or maximum time, whichever first
          if ((read_valid && !read_data[`LPI_AUTO_INIT_BIT]) || auto_cnt_r == '0) begin
            state_r <= LPI_CAL_GRANT;
          end else if (gap_r == '0) begin
            state_r <= LPI_POLL_CMD;
          end
        end
        // bus arbiter grants calibration to one memory at a time
        LPI_CAL_GRANT: if (cal_grant) state_r <= LPI_CAL_CMD;
        LPI_CAL_CMD: state_r <= LPI_CAL_WAIT;
        LPI_CAL_WAIT: if (tmr_done) state_r <= LPI_READY;
        LPI_READY: state_r <= LPI_READY;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_run <= 1'b0;
      clk_enable <= 1'b0;
      ca_rise <= `LPI_CA_NOP;
      ca_fall <= '0;
      ca_drive_n <= 1'b1;
      cal_request <= 1'b0;
      boot_timing <= 1'b1;
      ready <= 1'b0;
      auto_init_timeout <= 1'b0;
    end else begin
      // clock starts with the lead state so five cycles precede enable
      clk_run <= (state_r != LPI_GATE_LOW) || (sup_r && start && tmr_done);
      // enable held high from the idle period onward; no power-down is used
      clk_enable <= (state_r != LPI_GATE_LOW) && (state_r != LPI_CLK_LEAD ||
                    tmr_done);
      ca_drive_n <= !((state_r != LPI_GATE_LOW) && (state_r != LPI_CLK_LEAD));
      // one command per clock, both halves presented together
      ca_rise <= `LPI_CA_NOP;
      ca_fall <= '0;
      unique case (state_r)
        LPI_RESET_CMD: begin
          ca_rise <= {MA_RESET[5:0], `LPI_CA_MRW};
          ca_fall <= {`LPI_OP_RESET, MA_RESET[7:6]};
        end
        LPI_POLL_CMD: begin
          // reads only here, sent whatever the clock period; BOOT_CLK_OK only holds boot_timing high
          ca_rise <= {MA_INFO[5:0], `LPI_CA_MRR};
          ca_fall <= {8'h00, MA_INFO[7:6]};
        end
        LPI_CAL_CMD: begin
          ca_rise <= {MA_CAL[5:0], `LPI_CA_MRW};
          ca_fall <= {`LPI_OP_CAL_INIT, MA_CAL[7:6]};
        end
        default: begin
        end
      endcase
      // request and ready change on the same edge; relaxed timing drops with them only when BOOT_CLK_OK
      cal_request <= (state_r == LPI_CAL_GRANT) || (state_r == LPI_CAL_CMD) ||
                     (state_r == LPI_CAL_WAIT && !tmr_done);
      boot_timing <= !((state_r == LPI_CAL_WAIT && tmr_done) || state_r == LPI_READY) ||
                     !BOOT_CLK_OK;
      ready <= (state_r == LPI_CAL_WAIT && tmr_done) || state_r == LPI_READY;
      if (state_r == LPI_POLL_WAIT && auto_cnt_r == '0) begin
        auto_init_timeout <= 1'b1;
      end
    end
  end
endmodule // lpi_seq

// ### rtl/lpi_timer.sv
// Purpose: down-counting wait timer shared by the gate-low, clock lead, idle, post-reset and calibration waits
// Assumes: load and count come from the same clock domain
// Notes: done is high while the count is zero
`timescale 1ns/1ps
module lpi_timer import lpi_pkg::*; #(
  parameter int WIDTH = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic done
);
  logic [WIDTH-1:0] cnt_r;
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  assign done = (cnt_r == '0);
endmodule // lpi_timer

// ### tb/lpi_mem_model.sv
// Purpose: behavioural memory on the far side of the command bus
// Assumes: commands taken on the rising edge while the gate is high
// Notes: auto-init length set at run time through busy_len
`timescale 1ns/1ps
module lpi_mem_model (
  input wire logic clk,
  input wire logic clk_enable,
  input wire logic [9:0] ca_rise,
  input wire logic [9:0] ca_fall,
  input wire logic ca_drive_n,
  input wire logic [9:0] busy_len,
  output logic [7:0] read_data,
  output logic read_valid
);
  logic [9:0] busy_r = 10'h3FF;
  logic [1:0] rd_pipe_r = 2'b00;
  logic take;
  // ----------------------------------------
  // command intake and answers
  // ----------------------------------------
  initial begin
    read_data = 8'hA5;
    read_valid = 1'b0;
  end
  // nothing is taken while the gate is low or the bus is released
  assign take = clk_enable && !ca_drive_n;
  // auto-init runs from the reset write; calibration needs no answer
  always @(posedge clk) begin
    if (take && ca_rise == 10'h3F0 && ca_fall == 10'h000) begin
      busy_r <= busy_len;
    end else if (busy_r != 10'h000) begin
      busy_r <= busy_r - 10'h001;
    end
  end
  // reads answer two cycles late; idle data lines toggle so stale values never match
  always @(posedge clk) begin
    rd_pipe_r <= {rd_pipe_r[0], take && ca_rise == 10'h008 && ca_fall[1:0] == 2'b00};
    // one whole-byte answer per read; data bursts are not modelled here
    read_valid <= rd_pipe_r[1] && clk_enable;
    read_data <= (rd_pipe_r[1] && clk_enable) ? {7'h00, busy_r != 10'h000} : ~read_data;
  end
endmodule // lpi_mem_model

// ### tb/lpi_seq_monitor.sv
// Purpose: port checks for the power-up sequencer
// Assumes: one clock, sys_rst asynchronous active high
// Notes: helper counters measure waits in whole clock cycles
`timescale 1ns/1ps
`include "lpi_map.svh"
module lpi_seq_monitor import lpi_pkg::*; #(
  parameter int IDLE_CYCLES = 4000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic supplies_ok,
  input wire logic start,
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire logic cal_grant,
  input wire logic clk_run,
  input wire logic clk_enable,
  input wire logic [9:0] ca_rise,
  input wire logic [9:0] ca_fall,
  input wire logic ca_drive_n,
  input wire logic cal_request,
  input wire logic boot_timing,
  input wire logic ready,
  input wire logic auto_init_timeout
);
  localparam int GAP_CYC = 20; // 1 us rounded up to 50 ns cycles
  logic is_rst, is_mrr, is_cal;
  logic [19:0] cke_cnt_r, rst_cnt_r, cal_cnt_r;
  // ----------------------------------------
  // command decode and wait counters
  // ----------------------------------------
  assign is_rst = !ca_drive_n && ca_rise == 10'h3F0;
  assign is_mrr = !ca_drive_n && ca_rise == 10'h008;
  assign is_cal = !ca_drive_n && ca_rise == 10'h0A0;
  // cycles with the gate high, cleared whenever it drops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cke_cnt_r <= 20'h00000;
    else cke_cnt_r <= clk_enable ? cke_cnt_r + 20'h00001 : 20'h00000;
  end
  // zero until the reset write, so early reads cannot pass
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rst_cnt_r <= 20'h00000;
    else if (is_rst) rst_cnt_r <= 20'h00001;
    else if (rst_cnt_r != 20'h00000) rst_cnt_r <= rst_cnt_r + 20'h00001;
  end
  // cycles since the calibration write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cal_cnt_r <= 20'h00000;
    else if (is_cal) cal_cnt_r <= 20'h00001;
    else if (cal_cnt_r != 20'h00000) cal_cnt_r <= cal_cnt_r + 20'h00001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_clock_lead: assert property ($rose(clk_enable) |-> $past(clk_run, 5) && clk_run)
    else $error("gate rose without clock lead");
  a_gate_held: assert property (clk_enable |=> clk_enable)
    else $error("gate dropped during init");
  a_idle_nop: assert property ($rose(clk_enable) |-> (ca_rise == `LPI_CA_NOP) [*8])
    else $error("command during idle");
  a_reset_form: assert property (is_rst |-> ca_fall == 10'h000 ##1 ca_rise == `LPI_CA_NOP)
    else $error("bad reset write");
  a_idle_length: assert property (is_rst |-> cke_cnt_r >= IDLE_CYCLES)
    else $error("reset write too early");
  a_poll_gap: assert property (is_mrr |-> rst_cnt_r >= GAP_CYC && boot_timing)
    else $error("read too early");
  a_cal_write: assert property (is_cal |-> ca_fall == 10'h3FC && cal_request && !ready)
    else $error("bad calibration write");
  a_cal_time: assert property ($rose(ready) |-> cal_cnt_r >= GAP_CYC)
    else $error("ready before calibration time");
endmodule // lpi_seq_monitor
bind lpi_seq lpi_seq_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) u_mon (.clk(clk), .sys_rst(sys_rst),
  .supplies_ok(supplies_ok), .start(start), .read_data(read_data), .read_valid(read_valid),
  .cal_grant(cal_grant), .clk_run(clk_run), .clk_enable(clk_enable), .ca_rise(ca_rise),
  .ca_fall(ca_fall), .ca_drive_n(ca_drive_n), .cal_request(cal_request),
  .boot_timing(boot_timing), .ready(ready), .auto_init_timeout(auto_init_timeout));

// ### tb/sdram_powerup_init_sequence_bench.sv
// Purpose: self-checking bench for the power-up sequencer
// Assumes: idle wait shortened to 20 cycles
// Notes: the memory model answers mode reads two cycles late
`timescale 1ns/1ps
module sdram_powerup_init_sequence_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic supplies_ok = 1'b0;
  logic start = 1'b0;
  logic cal_grant = 1'b0;
  logic [9:0] busy_len = 10'h028;
  logic [7:0] read_data;
  logic read_valid, clk_run, clk_enable, ca_drive_n, cal_request, boot_timing, ready, timeout;
  logic [9:0] ca_rise, ca_fall;
  int err_count = 0;
  int num_checks = 0;
  int n;
  // ----------------------------------------
  // clock, design and memory model
  // ----------------------------------------
  always #25 clk = ~clk;
  lpi_seq #(.IDLE_CYCLES(20)) uut (.clk(clk), .sys_rst(sys_rst), .supplies_ok(supplies_ok),
    .start(start), .read_data(read_data), .read_valid(read_valid), .cal_grant(cal_grant),
    .clk_run(clk_run), .clk_enable(clk_enable), .ca_rise(ca_rise), .ca_fall(ca_fall),
    .ca_drive_n(ca_drive_n), .cal_request(cal_request), .boot_timing(boot_timing),
    .ready(ready), .auto_init_timeout(timeout));
  lpi_mem_model u_mem (.clk(clk), .clk_enable(clk_enable), .ca_rise(ca_rise),
    .ca_fall(ca_fall), .ca_drive_n(ca_drive_n), .busy_len(busy_len),
    .read_data(read_data), .read_valid(read_valid));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // bounded wait for a level; running out ends the run as a mismatch
  task automatic wait_on(ref logic sig, input int max);
    n = 0;
    while (sig !== 1'b1 && n < max) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (sig !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t ns: wait ran out", $time);
      finish_test();
    end
  endtask
  // reset, hold supplies low a while, then let the sequence run to the gate
  task automatic power_up(input logic [9:0] busy, input logic grant);
    @(posedge clk);
    sys_rst <= 1'b1;
    supplies_ok <= 1'b0;
    busy_len <= busy;
    cal_grant <= grant;
    start <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    check(clk_enable, 1'b0);
    check(ca_drive_n, 1'b1);
    @(posedge clk);
    supplies_ok <= 1'b1;
    wait_on(clk_run, 40);
    wait_on(clk_enable, 20);
    check(n[9:0], 10'h005);
  endtask
  task automatic t_normal();
    power_up(10'h028, 1'b1);
    wait_on(ready, 400);
    check(timeout, 1'b0);
    check(boot_timing, 1'b0);
    check(cal_request, 1'b0);
    repeat (5) @(posedge clk);
    #1;
    check(clk_enable, 1'b1);
    $display("test normal done");
  endtask
  task automatic t_mid_reset();
    power_up(10'h028, 1'b1);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    #1;
    check(clk_enable, 1'b0);
    check(ca_rise, 10'h007);
    check(ready, 1'b0);
    $display("test mid reset done");
  endtask
  task automatic t_slow_device();
    power_up(10'h12C, 1'b1); // 300 cycles, past the 200-cycle limit
    wait_on(ready, 600);
    check(timeout, 1'b1);
    $display("test slow device done");
  endtask
  task automatic t_grant_held();
    power_up(10'h028, 1'b0);
    wait_on(cal_request, 400);
    repeat (40) @(posedge clk);
    #1;
    check(ready, 1'b0);
    check(cal_request, 1'b1);
    @(posedge clk);
    cal_grant <= 1'b1;
    wait_on(ready, 80);
    check(n >= 20, 1'b1);
    $display("test grant held done");
  endtask
  initial begin
    t_normal();
    t_mid_reset();
    t_slow_device();
    t_grant_held();
    finish_test();
  end
endmodule // sdram_powerup_init_sequence_bench
